// ==== hw/asf_pkg.sv ====
// Package of constants and types for the converter control sequencer.
package asf_pkg;

  // Conversion mode encodings.
  typedef enum logic [1:0] {
    ASF_MODE_ONESHOT = 2'h0,
    ASF_MODE_REPEAT  = 2'h1,
    ASF_MODE_SWEEP   = 2'h2,
    ASF_MODE_RSWEEP  = 2'h3
  } asf_mode_e;

  // Configuration word field positions.
  localparam int unsigned CFG_THR_LSB   = 0;
  localparam int unsigned CFG_THR_MSB   = 1;
  localparam int unsigned CFG_SEQ_LSB   = 3;
  localparam int unsigned CFG_SEQ_MSB   = 4;
  localparam int unsigned CFG_MODE_LSB  = 5;
  localparam int unsigned CFG_MODE_MSB  = 6;
  localparam int unsigned CFG_EXTCLK    = 7;
  localparam int unsigned CFG_WIDTH     = 12;
  localparam logic [11:0] CFG_RESET     = 12'h000;

  // Conversion timing.
  localparam int unsigned CONV_CLKS_14  = 18;
  localparam int unsigned CONV_CLKS_12  = 13;
  localparam int unsigned SCLK_PER_CONV = 4;
  localparam int unsigned CONV_TAIL_NS  = 15;
  localparam int unsigned SYS_CLK_MHZ   = 50;
  localparam int unsigned TAIL_CYC      =
    (CONV_TAIL_NS * SYS_CLK_MHZ + 999) / 1000;

  // Result storage.
  localparam int unsigned FIFO_DEPTH    = 8;
  localparam int unsigned WORD_W        = 16;

  // Host command kinds after decoding.
  typedef struct packed {
    logic       valid;
    logic       cfg_write;
    logic       fifo_read;
    logic       select;
    logic [2:0] channel;
    logic [11:0] cfg_data;
  } asf_cmd_s;

  typedef enum logic [1:0] {
    ASF_ST_IDLE = 2'b00,
    ASF_ST_CONV = 2'b01,
    ASF_ST_TAIL = 2'b11,
    ASF_ST_DOWN = 2'b10
  } asf_state_e;

endpackage : asf_pkg

// ==== hw/asf_seq.sv ====
// Converter control sequencer with result FIFO and auto power-down.
`timescale 1ns/1ps
`default_nettype none

module asf_seq
  import asf_pkg::*;
#(
  parameter bit          RES14     = 1'b1,
  parameter int unsigned OSC_DIV   = 8
)
(
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              reset_n,
  input  wire logic              clk_en,
  // Pins from the host, asynchronous
  input  wire logic              chip_sel_n,
  input  wire logic              frame_sync_in,
  input  wire logic              ext_convert_trigger_n,
  input  wire logic              serial_clk,
  // Decoded command from the serial shifter, same clock
  input  wire asf_cmd_s          cmd,
  // Conversion result from the analog core
  input  wire logic [13:0]       conv_result,
  // Outputs
  output logic                   eoc_out,
  output logic                   int_out_n,
  output logic                   power_down,
  output logic [WORD_W-1:0]      fifo_out_word,
  output logic                   out_drive,
  output logic [WORD_W-1:0]      last_word,
  output logic [2:0]             conv_channel,
  output logic [3:0]             fifo_count,
  output logic [CFG_WIDTH-1:0]   config_word
);

  localparam int unsigned NCONV = RES14 ? CONV_CLKS_14 : CONV_CLKS_12;

  // Sweep channel lists, indexed by sequence select and position.
  function automatic logic [2:0] sweep_ch(input logic [1:0] sel,
                                          input logic [2:0] pos);
    logic [2:0] ch;
    ch = 3'h0;
    unique case (sel)
      2'h0: ch = {pos[2:1], 1'b0};
      2'h1: ch = {pos[2], pos[1], 1'b0} & 3'h6;
      2'h2: ch = pos;
      2'h3: ch = {pos[1:0], 1'b0};
    endcase
    return ch;
  endfunction

  // Threshold decode: 1, 2, 4 or 8 entries.
  function automatic logic [3:0] thr_count(input logic [1:0] t);
    return 4'h1 << t;
  endfunction

  // Justify the raw result per resolution.
  function automatic logic [WORD_W-1:0] pack_word(input logic [13:0] r);
    return RES14 ? {r, 2'h0} : {r[13:2], 4'h0};
  endfunction

  // Two-stage synchronisers for the host pins.
  logic [3:0] pin_s1_q;
  logic [3:0] pin_s2_q;
  logic [3:0] pin_s3_q;
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin_s1_q <= 4'hf;
      pin_s2_q <= 4'hf;
      pin_s3_q <= 4'hf;
    end
    else if (clk_en)
    begin
      pin_s1_q <= {serial_clk, ext_convert_trigger_n, frame_sync_in,
                   chip_sel_n};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  logic cs_fall;
  logic fs_rise;
  logic trg_rise;
  logic sclk_rise;
  assign cs_fall   = pin_s3_q[0] & ~pin_s2_q[0];
  assign fs_rise   = ~pin_s3_q[1] & pin_s2_q[1];
  assign trg_rise  = ~pin_s3_q[2] & pin_s2_q[2];
  assign sclk_rise = ~pin_s3_q[3] & pin_s2_q[3];

  asf_mode_e mode;
  assign mode = asf_mode_e'(config_word[CFG_MODE_MSB:CFG_MODE_LSB]);
  logic use_fifo;
  assign use_fifo = (mode != ASF_MODE_ONESHOT);

  // Configuration register; a write also clears the FIFO, the arming and the sweep position.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      config_word <= CFG_RESET;
    else if (clk_en && cmd.valid && cmd.cfg_write)
      config_word <= cmd.cfg_data;
  end

  // Conversion clock tick. Both dividers restart with each conversion so
  // that its first conversion clock is a whole one, not a leftover piece.
  logic [7:0] osc_cnt_q;
  logic [1:0] sdiv_q;
  logic       conv_tick;
  logic       start_req;
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      osc_cnt_q <= 8'h00;
      sdiv_q    <= 2'h0;
    end
    else if (clk_en)
    begin
      if (start_req)
      begin
        osc_cnt_q <= 8'h00;
        sdiv_q    <= 2'h0;
      end
      else
      begin
        osc_cnt_q <= (osc_cnt_q == 8'(OSC_DIV - 1)) ? 8'h00 :
                     osc_cnt_q + 8'h01;
        if (sclk_rise)
          sdiv_q <= sdiv_q + 2'h1;
      end
    end
  end
  assign conv_tick = config_word[CFG_EXTCLK] ?
                     (sclk_rise && sdiv_q == 2'h3) :
                     (osc_cnt_q == 8'(OSC_DIV - 1));

  // Sequencer state.
  asf_state_e state_q;
  logic [4:0] conv_cnt_q;
  logic [3:0] tail_cnt_q;
  logic       armed_q;
  logic       done_q;
  logic [2:0] sweep_pos_q;
  logic [2:0] fixed_ch_q;
  logic       rd_active_q;
  logic       post_int_q;

  logic is_sel;
  logic wake;
  logic conv_end;
  assign is_sel   = cmd.valid && cmd.select;
  assign wake     = cs_fall | fs_rise | trg_rise;
  assign conv_end = (state_q == ASF_ST_TAIL) && (tail_cnt_q == 4'h0);

  // Start decision per mode; reads and writes never start.
  always_comb
  begin
    start_req = 1'b0;
    if (state_q == ASF_ST_IDLE || state_q == ASF_ST_DOWN)
    begin
      unique case (mode)
        ASF_MODE_ONESHOT: start_req = is_sel || trg_rise;
        ASF_MODE_REPEAT:  start_req = is_sel || (trg_rise && armed_q);
        ASF_MODE_SWEEP:   start_req = !done_q &&
                                      (is_sel || (trg_rise && armed_q));
        ASF_MODE_RSWEEP:  start_req = is_sel || (trg_rise && armed_q);
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q    <= ASF_ST_DOWN;
      conv_cnt_q <= 5'h00;
      tail_cnt_q <= 4'h0;
    end
    else if (clk_en)
    begin
      unique case (state_q)
        ASF_ST_IDLE, ASF_ST_DOWN:
          if (start_req)
          begin
            state_q    <= ASF_ST_CONV;
            conv_cnt_q <= 5'(NCONV);
          end
          else if (wake)
            state_q <= ASF_ST_IDLE;
        ASF_ST_CONV:
          if (conv_tick)
          begin
            conv_cnt_q <= conv_cnt_q - 5'h01;
            if (conv_cnt_q == 5'h01)
            begin
              state_q    <= ASF_ST_TAIL;
              tail_cnt_q <= 4'(TAIL_CYC - 1);
            end
          end
        ASF_ST_TAIL:
          if (tail_cnt_q == 4'h0)
            state_q <= ASF_ST_DOWN;
          else
            tail_cnt_q <= tail_cnt_q - 4'h1;
      endcase
    end
  end

  // Arming: a select cycle arms trigger-driven conversions.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      armed_q <= 1'b0;
    else if (clk_en)
    begin
      if (is_sel)
        armed_q <= 1'b1;
      else if (cmd.valid && (cmd.cfg_write || cmd.fifo_read))
        armed_q <= 1'b0;
    end
  end

  // Channel tracking; a select during a sweep is a dummy.
  // The new channel must reach the conversion started by the same select.
  logic [2:0] fixed_ch_d;
  assign fixed_ch_d = (is_sel && (mode == ASF_MODE_ONESHOT || !armed_q)) ?
                      cmd.channel : fixed_ch_q;
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fixed_ch_q  <= 3'h0;
      sweep_pos_q <= 3'h0;
    end
    else if (clk_en)
    begin
      fixed_ch_q <= fixed_ch_d;
      if (cmd.valid && cmd.cfg_write)
        sweep_pos_q <= 3'h0;
      else if (conv_end && mode[1])
        sweep_pos_q <= sweep_pos_q + 3'h1;
      else if (state_q == ASF_ST_DOWN && wake && done_q)
        sweep_pos_q <= 3'h0;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      conv_channel <= 3'h0;
    else if (clk_en && start_req)
      conv_channel <= mode[1] ?
        sweep_ch(config_word[CFG_SEQ_MSB:CFG_SEQ_LSB], sweep_pos_q) :
        fixed_ch_d;
  end

  // Result FIFO storage.
  logic [WORD_W-1:0] mem_q [FIFO_DEPTH];
  logic [2:0]        wr_ptr_q;
  logic [2:0]        rd_ptr_q;
  logic              fifo_wr;
  logic              restart;
  assign fifo_wr = conv_end && use_fifo;
  assign restart = start_req && done_q &&
                   (mode == ASF_MODE_RSWEEP || mode == ASF_MODE_REPEAT);

  always_ff @(posedge sys_clk)
  begin
    if (clk_en && fifo_wr)
      mem_q[restart ? 3'h0 : wr_ptr_q] <= pack_word(conv_result);
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_ptr_q   <= 3'h0;
      rd_ptr_q   <= 3'h0;
      fifo_count <= 4'h0;
      done_q     <= 1'b0;
    end
    else if (clk_en)
    begin
      if (cmd.valid && cmd.cfg_write)
      begin
        wr_ptr_q   <= 3'h0;
        rd_ptr_q   <= 3'h0;
        fifo_count <= 4'h0;
        done_q     <= 1'b0;
      end
      else if (restart)
      begin
        wr_ptr_q   <= 3'h0;
        rd_ptr_q   <= 3'h0;
        fifo_count <= 4'h0;
        done_q     <= 1'b0;
      end
      else if (fifo_wr)
      begin
        wr_ptr_q   <= wr_ptr_q + 3'h1;
        fifo_count <= fifo_count + 4'h1;
        if (fifo_count + 4'h1 >=
            thr_count(config_word[CFG_THR_MSB:CFG_THR_LSB]))
          done_q <= 1'b1;
      end
      else if (rd_active_q && cmd.valid && cmd.fifo_read)
      begin
        rd_ptr_q   <= rd_ptr_q + 3'h1;
        fifo_count <= fifo_count - 4'h1;
        if (fifo_count == 4'h1)
          done_q <= 1'b0;
      end
      else if (rd_active_q && cmd.valid)
      begin
        rd_ptr_q   <= wr_ptr_q;
        fifo_count <= 4'h0;
        done_q     <= 1'b0;
      end
    end
  end

  // Read session: head word presented before the command decodes.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      post_int_q    <= 1'b0;
      rd_active_q   <= 1'b0;
      out_drive     <= 1'b0;
      fifo_out_word <= 16'h0000;
    end
    else if (clk_en)
    begin
      if (fifo_wr && fifo_count + 4'h1 >=
          thr_count(config_word[CFG_THR_MSB:CFG_THR_LSB]))
        post_int_q <= 1'b1;
      else if (cmd.valid && post_int_q)
        post_int_q <= 1'b0;
      if (post_int_q && (cs_fall || fs_rise))
      begin
        rd_active_q   <= 1'b1;
        out_drive     <= 1'b1;
        fifo_out_word <= mem_q[rd_ptr_q];
      end
      else if (rd_active_q && cmd.valid && cmd.fifo_read &&
               fifo_count > 4'h1)
        fifo_out_word <= mem_q[rd_ptr_q + 3'h1];
      else if (rd_active_q && cmd.valid &&
               (!cmd.fifo_read || fifo_count <= 4'h1))
      begin
        rd_active_q <= 1'b0;
        out_drive   <= 1'b0;
      end
    end
  end

  // Mode 00 result kept for the next select cycle.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      last_word <= 16'h0000;
    else if (clk_en && conv_end && !use_fifo)
      last_word <= pack_word(conv_result);
  end

  // Flags; only a conversion end drives int_out_n active, and only reset or a conversion end sets power_down; eoc_out goes low from the start request on.
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      eoc_out    <= 1'b1;
      int_out_n  <= 1'b1;
      power_down <= 1'b1;
    end
    else if (clk_en)
    begin
      eoc_out <= !(start_req || state_q == ASF_ST_CONV ||
                   (state_q == ASF_ST_TAIL && !conv_end));
      if (conv_end && (!use_fifo || fifo_count + 4'h1 >=
          thr_count(config_word[CFG_THR_MSB:CFG_THR_LSB])))
        int_out_n <= 1'b0;
      else if (cmd.valid && (cmd.cfg_write || cmd.fifo_read || cmd.select))
        int_out_n <= 1'b1;
      if (conv_end)
        power_down <= 1'b1;
      else if (wake || start_req)
        power_down <= 1'b0;
    end
  end

  // Assertions.
  sequence s_cfg_wr;
    cmd.valid && cmd.cfg_write && clk_en;
  endsequence

  property p_cfg_no_conv;
    @(posedge sys_clk) disable iff (!reset_n)
    (s_cfg_wr and state_q == ASF_ST_IDLE) |=>
      eoc_out && state_q != ASF_ST_CONV;
  endproperty
  a_cfg_no_conv: assert property (p_cfg_no_conv)
    else $error("config write started a conversion");

  property p_cfg_clear;
    @(posedge sys_clk) disable iff (!reset_n)
    s_cfg_wr |=> fifo_count == 4'h0;
  endproperty
  a_cfg_clear: assert property (p_cfg_clear)
    else $error("fifo not cleared by config write");

  property p_int_release;
    @(posedge sys_clk) disable iff (!reset_n)
    (s_cfg_wr and !conv_end) |=> int_out_n;
  endproperty
  a_int_release: assert property (p_int_release)
    else $error("interrupt not released");

  property p_eoc_low;
    @(posedge sys_clk) disable iff (!reset_n)
    clk_en && state_q == ASF_ST_CONV |=> !eoc_out;
  endproperty
  a_eoc_low: assert property (p_eoc_low)
    else $error("eoc high during conversion");

  property p_pd_end;
    @(posedge sys_clk) disable iff (!reset_n)
    clk_en && conv_end |=> power_down && state_q == ASF_ST_DOWN;
  endproperty
  a_pd_end: assert property (p_pd_end)
    else $error("no power-down after conversion");

  property p_cnt_max;
    @(posedge sys_clk) disable iff (!reset_n)
    fifo_count <= 4'(FIFO_DEPTH);
  endproperty
  a_cnt_max: assert property (p_cnt_max)
    else $error("fifo count above depth");

  property p_mode0_nofifo;
    @(posedge sys_clk) disable iff (!reset_n)
    clk_en && !use_fifo && !(cmd.valid && cmd.cfg_write) |=>
      $stable(fifo_count);
  endproperty
  a_mode0_nofifo: assert property (p_mode0_nofifo)
    else $error("fifo written in mode 00");

  property p_nonread_stop;
    @(posedge sys_clk) disable iff (!reset_n)
    clk_en && rd_active_q && cmd.valid && !cmd.fifo_read |=> !out_drive;
  endproperty
  a_nonread_stop: assert property (p_nonread_stop)
    else $error("output not stopped on non-read");

  property p_read_noconv;
    @(posedge sys_clk) disable iff (!reset_n)
    clk_en && cmd.valid && cmd.fifo_read && !cmd.select |-> !start_req;
  endproperty
  a_read_noconv: assert property (p_read_noconv)
    else $error("fifo read started conversion");

endmodule // asf_seq

`default_nettype wire

// ==== verification/asf_host_model.sv ====
// Host serial master model: wake-up pins, serial clock and decoded commands.
`timescale 1ns/1ps
`default_nettype none

module asf_host_model
  import asf_pkg::*;
(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic reset_n,
  // Serial clock run request from the bench
  input  wire logic sclk_run,
  // Toward the device
  output logic      chip_sel_n,
  output logic      frame_sync_in,
  output logic      ext_convert_trigger_n,
  output logic      serial_clk,
  output asf_cmd_s  cmd
);
  logic div_q;

  initial
  begin
    chip_sel_n = 1'b1;
    frame_sync_in = 1'b0;
    ext_convert_trigger_n = 1'b1;
    serial_clk = 1'b0;
    cmd = '0;
    div_q = 1'b0;
  end

  // The serial clock runs only while sclk_run is high and rests low otherwise.
  always @(negedge sys_clk)
  begin
    div_q <= sclk_run & ~div_q;
    if (!sclk_run || !reset_n)
      serial_clk <= 1'b0;
    else if (div_q)
      serial_clk <= ~serial_clk;
  end

  // One framed command; kind 0 writes config, 1 reads, 2 selects.
  task automatic send(input int kind, input logic [2:0] ch,
                      input logic [11:0] data);
    @(negedge sys_clk);
    chip_sel_n <= 1'b0;
    repeat (4) @(negedge sys_clk);
    cmd <= '{1'b1, kind == 0, kind == 1, kind == 2, ch, data};
    @(negedge sys_clk);
    cmd <= '0;
    chip_sel_n <= 1'b1;
  endtask

  // Pulse on one wake-up pin: 0 select, 1 frame sync, 2 trigger.
  task automatic pulse(input int which);
    @(negedge sys_clk);
    chip_sel_n <= (which != 0);
    frame_sync_in <= (which == 1);
    ext_convert_trigger_n <= (which != 2);
    repeat (2) @(negedge sys_clk);
    chip_sel_n <= 1'b1;
    frame_sync_in <= 1'b0;
    ext_convert_trigger_n <= 1'b1;
  endtask
endmodule // asf_host_model

`default_nettype wire

// ==== verification/tb_top.sv ====
// Self-checking bench for the converter control sequencer.
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import asf_pkg::*;
;
  localparam int OSCD = 2;
  localparam int NC   = CONV_CLKS_14;
  localparam int LO   = NC * OSCD;
  localparam int HI   = LO + 4;

  logic        sys_clk;
  logic        reset_n;
  logic        clk_en;
  logic        sclk_run;
  logic        chip_sel_n;
  logic        frame_sync_in;
  logic        ext_convert_trigger_n;
  logic        serial_clk;
  asf_cmd_s    cmd;
  logic [13:0] conv_result;
  logic        eoc_out;
  logic        int_out_n;
  logic        power_down;
  logic [15:0] fifo_out_word;
  logic        out_drive;
  logic [15:0] last_word;
  logic [2:0]  conv_channel;
  logic [3:0]  fifo_count;
  logic [11:0] config_word;
  logic [15:0] expq[$];
  int          miscompares;
  int          checked;
  int          cyc;

  asf_host_model i_host (
    .sys_clk(sys_clk), .reset_n(reset_n), .sclk_run(sclk_run),
    .chip_sel_n(chip_sel_n), .frame_sync_in(frame_sync_in),
    .ext_convert_trigger_n(ext_convert_trigger_n),
    .serial_clk(serial_clk), .cmd(cmd)
  );

  asf_seq #(.RES14(1'b1), .OSC_DIV(OSCD)) i_dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
    .chip_sel_n(chip_sel_n), .frame_sync_in(frame_sync_in),
    .ext_convert_trigger_n(ext_convert_trigger_n),
    .serial_clk(serial_clk), .cmd(cmd), .conv_result(conv_result),
    .eoc_out(eoc_out), .int_out_n(int_out_n), .power_down(power_down),
    .fifo_out_word(fifo_out_word), .out_drive(out_drive),
    .last_word(last_word), .conv_channel(conv_channel),
    .fifo_count(fifo_count), .config_word(config_word)
  );

  always #10 sys_clk = ~sys_clk;

  task automatic test_done();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // A hang would otherwise never reach the verdict.
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      $display("Error at %0t: timeout", $time);
      test_done();
    end
  end

  task automatic cmp_bit(input logic a, input logic e, input string m);
    checked++;
    if (a !== e)
    begin
      miscompares++;
      $display("Error at %0t: %s got %b exp %b", $time, m, a, e);
    end
  endtask

  task automatic cmp_word(input logic [15:0] a, input logic [15:0] e,
                          input string m);
    checked++;
    if (a !== e)
    begin
      miscompares++;
      $display("Error at %0t: %s got %h exp %h", $time, m, a, e);
    end
  endtask

  function automatic logic [15:0] exp_word(input logic [13:0] r);
    return {r, 2'b00};
  endfunction

  task automatic wr_cfg(input logic [1:0] md, input logic [1:0] thr,
                        input logic ext);
    logic [11:0] v;
    v = 12'h000;
    v[CFG_THR_MSB:CFG_THR_LSB] = thr;
    v[CFG_MODE_MSB:CFG_MODE_LSB] = md;
    v[CFG_EXTCLK] = ext;
    i_host.send(0, 3'h0, v);
    expq.delete();
    cmp_word({4'h0, config_word}, {4'h0, v}, "config");
    cmp_word({12'h000, fifo_count}, 16'h0000, "cleared");
  endtask

  // The analog result is held for the whole conversion on purpose.
  task automatic conv(input logic [2:0] ch, input int lo = LO,
                      input int hi = HI);
    int n;
    conv_result = 14'($urandom);
    expq.push_back(exp_word(conv_result));
    i_host.send(2, ch, 12'h000);
    n = 0;
    while (eoc_out !== 1'b0 && n < 20)
    begin
      @(negedge sys_clk);
      n++;
    end
    n = 0;
    while (eoc_out !== 1'b1 && n < 4000)
    begin
      @(negedge sys_clk);
      n++;
    end
    cmp_bit(n >= lo && n <= hi, 1'b1, "conv length");
    cmp_bit(power_down, 1'b1, "auto power-down");
  endtask

  task automatic eoc_idle(input int n, input string m);
    logic ok;
    ok = 1'b1;
    repeat (n)
    begin
      @(negedge sys_clk);
      if (eoc_out !== 1'b1) ok = 1'b0;
    end
    cmp_bit(ok, 1'b1, m);
  endtask

  // Except in the threshold-8 repeat pass, where a config write ends the read, the bench drains every stored entry once reading starts.
  task automatic rd_all();
    i_host.pulse(0);
    repeat (4) @(negedge sys_clk);
    while (expq.size() > 0)
    begin
      cmp_bit(out_drive, 1'b1, "drive");
      cmp_word(fifo_out_word, expq.pop_front(), "fifo word");
      i_host.send(1, 3'h0, 12'h000);
      @(negedge sys_clk);
      cmp_bit(eoc_out, 1'b1, "read eoc");
      cmp_bit(int_out_n, 1'b1, "read int");
    end
    cmp_bit(out_drive, 1'b0, "drive end");
    cmp_word({12'h000, fifo_count}, 16'h0000, "empty");
  endtask

  initial
  begin
    int t;
    logic [2:0] ch;
    sys_clk = 1'b0;
    reset_n = 1'b0;
    clk_en = 1'b1;
    sclk_run = 1'b0;
    conv_result = 14'h0000;
    miscompares = 0;
    checked = 0;
    cyc = 0;
    t = $urandom(40674);
    repeat (2) @(negedge sys_clk);
    cmp_bit(eoc_out, 1'b1, "reset eoc");
    cmp_bit(int_out_n, 1'b1, "reset int");
    cmp_word({12'h000, fifo_count}, 16'h0000, "reset count");
    reset_n = 1'b1;
    $display("test reset done");

    wr_cfg(ASF_MODE_REPEAT, 2'($urandom), 1'b0);
    eoc_idle(20, "cfg idle");
    cmp_bit(int_out_n, 1'b1, "cfg int");
    $display("test config done");

    wr_cfg(ASF_MODE_ONESHOT, 2'h0, 1'b0);
    repeat (3)
    begin
      ch = 3'($urandom);
      conv(ch);
      cmp_word({13'h0, conv_channel}, {13'h0, ch}, "channel");
      cmp_word(last_word, expq.pop_back(), "last word");
    end
    cmp_word({12'h000, fifo_count}, 16'h0000, "no fifo");
    conv_result = 14'($urandom);
    i_host.pulse(2);
    repeat (4) @(negedge sys_clk);
    cmp_bit(power_down, 1'b0, "trigger wake");
    repeat (100) @(negedge sys_clk);
    cmp_word(last_word, exp_word(conv_result), "trigger result");
    $display("test one-shot done");

    // Serial clock divided by four: sixteen system clocks per tick.
    wr_cfg(ASF_MODE_ONESHOT, 2'h0, 1'b1);
    @(negedge sys_clk);
    sclk_run <= 1'b1;
    conv(3'h1, NC * 16, NC * 16 + 24);
    sclk_run = 1'b0;
    $display("test external clock done");

    for (int c = 0; c < 4; c++)
    begin
      wr_cfg(ASF_MODE_REPEAT, 2'(c), 1'b0);
      ch = 3'($urandom);
      for (int i = 0; i < (1 << c); i++)
      begin
        cmp_bit(int_out_n, 1'b1, "int early");
        conv(ch);
      end
      cmp_bit(int_out_n, 1'b0, "int at threshold");
      cmp_word({12'h000, fifo_count}, 16'(1 << c), "count");
      i_host.pulse(c % 2);
      repeat (4) @(negedge sys_clk);
      cmp_bit(power_down, 1'b0, "wake");
      cmp_word({12'h000, fifo_count}, 16'(1 << c), "kept");
      cmp_word({14'h0, config_word[1:0]}, 16'(c), "cfg kept");
      if (c < 3)
        rd_all();
      else
      begin
        wr_cfg(ASF_MODE_REPEAT, 2'h3, 1'b0);
        cmp_bit(out_drive, 1'b0, "drive stop");
        cmp_bit(int_out_n, 1'b1, "int release");
      end
    end
    $display("test repeat done");

    wr_cfg(ASF_MODE_SWEEP, 2'h0, 1'b0);
    conv(3'h0);
    i_host.send(2, 3'h5, 12'h000);
    eoc_idle(40, "start refused");
    wr_cfg(ASF_MODE_SWEEP, 2'h0, 1'b0);
    conv(3'h0);
    rd_all();
    conv(3'h0);
    $display("test sweep done");

    wr_cfg(ASF_MODE_RSWEEP, 2'h1, 1'b0);
    repeat (4) conv(3'h0);
    expq.delete(0);
    expq.delete(0);
    cmp_word({12'h000, fifo_count}, 16'h0002, "overwrite");
    // A frozen block must ignore a configuration write entirely.
    clk_en = 1'b0;
    i_host.send(0, 3'h0, 12'h000);
    cmp_word({12'h000, fifo_count}, 16'h0002, "frozen");
    clk_en = 1'b1;
    rd_all();
    $display("test repeat sweep done");
    test_done();
  end
endmodule // tb_top

`default_nettype wire
